// ### hdl/rcpc_top.sv
// reset cause bookkeeping and power-on-clear sequencing
// Rules from the document
// R1 - watchdog flag: set, held, or cleared by source
// R2 - low-voltage flag: set, held, or cleared by source
// R3 - cause register zeroed by pin, power-on, read
// R4 - low-voltage registers survive only low-voltage reset
// R5 - software reads cause register as whole byte
// R6 - internal resets leave other state untouched
// R7 - low mode: hold until above detect level
// R8 - high mode: release only above release level
// R9 - below detect level always asserts reset
// R10 - high mode adds stabilization wait, then processing
// R11 - software arms low-voltage detector after release
// R12 - software sets pins and pull-downs after release
// R13 - reset pin held low until supply good
// R14 - software waits out supply fluctuation by timer
// R15 - extended register transfer may break on reset
// R16 - unused cause bits read zero, ignore writes
module rcpc_top #(
    parameter logic [15:0] STAB_CYCLES = 16'(rcpc_pkg::STAB_WAIT_CYC)
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // reset sources and comparators, asynchronous
    input wire logic ext_reset_pin_n_in,
    input wire logic supply_below_detect_in,
    input wire logic supply_above_release_in,
    input wire logic lowvolt_reset_req_in,
    input wire logic lowvolt_det_flag_in,
    input wire logic poweron_threshold_select_in,
    // reset source on the system clock
    input wire logic watchdog_reset_req_in,
    // register port
    input wire logic [15:0] addr_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out,
    // results
    output logic internal_reset_out,
    output logic [7:0] lowvolt_control_out,
    output logic [3:0] lowvolt_level_out
);
    // two-stage synchronisers: stage 1 feeds stage 2 only
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic [5:0] async_in;
    assign async_in = {poweron_threshold_select_in, lowvolt_det_flag_in, lowvolt_reset_req_in,
                       supply_above_release_in, supply_below_detect_in, ~ext_reset_pin_n_in};

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
        end
        else
        begin
            sync1_q <= async_in;
            sync2_q <= sync1_q;
        end
    end

    logic ext_low;
    logic poc_low;
    logic rel_ok;
    logic lvi_req;
    logic lv_det;
    logic strap;
    assign ext_low = sync2_q[0];
    assign poc_low = sync2_q[1];
    assign rel_ok = sync2_q[2];
    assign lvi_req = sync2_q[3];
    assign lv_det = sync2_q[4];
    assign strap = sync2_q[5];

    // threshold option caught once, after the synchroniser has filled
    logic [1:0] strap_cnt_q;
    logic mode_q;
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            strap_cnt_q <= 2'h0;
            mode_q <= 1'b0;
        end
        else if (strap_cnt_q != rcpc_pkg::STRAP_TAKE_CNT)
        begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q + 2'h1 == rcpc_pkg::STRAP_TAKE_CNT)
                mode_q <= strap;
        end
    end

    // edge events of each source
    logic [3:0] src_prev_q;
    logic wdt_prev_q;
    logic ext_ev;
    logic poc_ev;
    logic lvi_ev;
    logic wdt_ev;
    logic clear_ev;
    assign ext_ev = ext_low & ~src_prev_q[0];
    assign poc_ev = poc_low & ~src_prev_q[1];
    assign lvi_ev = lvi_req & ~src_prev_q[3];
    assign wdt_ev = watchdog_reset_req_in & ~wdt_prev_q;
    assign clear_ev = ext_ev | poc_ev;

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            src_prev_q <= 4'h0;
            wdt_prev_q <= 1'b0;
        end
        else
        begin
            src_prev_q <= sync2_q[3:0];
            wdt_prev_q <= watchdog_reset_req_in;
        end
    end

    // power-on latch: from power application until the release level is seen
    logic poc_latch_q;
    logic poc_active;
    // R8 release above high level
    assign poc_active = mode_q ? (poc_latch_q | poc_low) : poc_low;
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            poc_latch_q <= 1'b1;
        else if (poc_low)
            poc_latch_q <= 1'b1;
        else if (rel_ok)
            poc_latch_q <= 1'b0;
    end

    // sequencer
    rcpc_pkg::rcpc_state_t state_q;
    rcpc_pkg::rcpc_state_t state_d;
    logic stab_need_q;
    logic any_src;
    rcpc_tmr_if #(.W(rcpc_pkg::TMR_W)) tif ();

    // R7 R9 hold while below detect level
    assign any_src = ext_low | poc_active | watchdog_reset_req_in | lvi_req;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            rcpc_pkg::ST_HOLD:
                if (!any_src)
                    state_d = (mode_q && stab_need_q) ? rcpc_pkg::ST_STAB : rcpc_pkg::ST_PROC;
            // R10 stabilization wait
            rcpc_pkg::ST_STAB:
                if (any_src)
                    state_d = rcpc_pkg::ST_HOLD;
                else if (tif.done)
                    state_d = rcpc_pkg::ST_PROC;
            rcpc_pkg::ST_PROC:
                if (any_src)
                    state_d = rcpc_pkg::ST_HOLD;
                else if (tif.done)
                    state_d = rcpc_pkg::ST_RUN;
            rcpc_pkg::ST_RUN:
                if (any_src)
                    state_d = rcpc_pkg::ST_HOLD;
            default:
                state_d = rcpc_pkg::ST_HOLD;
        endcase
    end

    assign tif.start = (state_d != state_q) &&
                       (state_d == rcpc_pkg::ST_STAB || state_d == rcpc_pkg::ST_PROC);
    assign tif.load = (state_d == rcpc_pkg::ST_STAB) ? STAB_CYCLES : 16'(rcpc_pkg::PROC_CYC);

    rcpc_timer #(.W(rcpc_pkg::TMR_W)) u_timer (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .tif(tif)
    );

    // the wait applies only when a power-on reset was part of this hold
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_q <= rcpc_pkg::ST_HOLD;
            stab_need_q <= 1'b1;
            internal_reset_out <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            internal_reset_out <= (state_d != rcpc_pkg::ST_RUN);
            if (poc_active)
                stab_need_q <= 1'b1;
            else if (state_q == rcpc_pkg::ST_HOLD && state_d != rcpc_pkg::ST_HOLD)
                stab_need_q <= 1'b0;
        end
    end

    // register decode
    logic rd_cause;
    logic wr_lvctl;
    logic wr_lvlvl;
    logic [7:0] cause_q;
    logic [7:0] cause_d;
    logic [7:0] lvctl_view;
    logic [7:0] rd_mux;
    assign rd_cause = rd_in && (addr_in == rcpc_pkg::CAUSE_ADDR);
    assign wr_lvctl = wr_in && (addr_in == rcpc_pkg::LV_CTL_ADDR);
    assign wr_lvlvl = wr_in && (addr_in == rcpc_pkg::LV_LVL_ADDR);
    assign lvctl_view = (lowvolt_control_out & rcpc_pkg::LV_CTL_WMASK) |
                        {7'h00, lv_det};
    assign rd_mux = (addr_in == rcpc_pkg::CAUSE_ADDR) ? cause_q :
                    (addr_in == rcpc_pkg::LV_CTL_ADDR) ? lvctl_view :
                    (addr_in == rcpc_pkg::LV_LVL_ADDR) ? {4'h0, lowvolt_level_out} :
                    rcpc_pkg::UNMAPPED_DATA;

    // R1 R2 R3 cause flag update
    // a hardware event in the cycle of a read survives the read clear
    always_comb
    begin
        cause_d = cause_q;
        if (rd_cause)
            cause_d = rcpc_pkg::CAUSE_RESET;
        if (wdt_ev)
            cause_d[rcpc_pkg::WDT_FLAG_BIT] = 1'b1;
        if (lvi_ev)
            cause_d[rcpc_pkg::LV_FLAG_BIT] = 1'b1;
        if (clear_ev)
            cause_d = rcpc_pkg::CAUSE_RESET;
        // R16 unused bits forced to zero
        cause_d = cause_d & rcpc_pkg::CAUSE_USED_MASK;
    end

    // R6 only the reset sources above and register reads touch these registers
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cause_q <= rcpc_pkg::CAUSE_RESET;
            rdata_out <= rcpc_pkg::UNMAPPED_DATA;
        end
        else
        begin
            cause_q <= cause_d;
            if (rd_in)
                rdata_out <= rd_mux;
        end
    end

    // R4 low-voltage registers kept over low-voltage reset
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            lowvolt_control_out <= rcpc_pkg::LV_CTL_RESET;
            lowvolt_level_out <= rcpc_pkg::LV_LVL_RESET;
        end
        else if (clear_ev || wdt_ev)
        begin
            lowvolt_control_out <= rcpc_pkg::LV_CTL_RESET;
            lowvolt_level_out <= rcpc_pkg::LV_LVL_RESET;
        end
        else
        begin
            if (wr_lvctl)
                lowvolt_control_out <= wdata_in & rcpc_pkg::LV_CTL_WMASK;
            if (wr_lvlvl)
                lowvolt_level_out <= wdata_in[3:0];
        end
    end

    // checking helpers: cycles spent in the current state
    logic [15:0] st_cnt_q;
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            st_cnt_q <= 16'h0000;
        else if (state_d != state_q)
            st_cnt_q <= 16'h0000;
        else
            st_cnt_q <= st_cnt_q + 16'h0001;
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    wdt_flag_set_a: assert property (wdt_ev && !clear_ev |=> cause_q[4]) // R1
        else $error("watchdog flag not set");
    wdt_flag_hold_a: assert property (lvi_ev && !wdt_ev && !clear_ev && !rd_cause |=> $stable(cause_q[4])) // R1
        else $error("watchdog flag changed by low-voltage reset");
    lv_flag_set_a: assert property (lvi_ev && !clear_ev |=> cause_q[0]) // R2
        else $error("low-voltage flag not set");
    cause_clear_a: assert property (clear_ev |=> cause_q == 8'h00) // R3
        else $error("cause register not cleared by pin or power-on");
    read_clear_a: assert property (rd_cause && !wdt_ev && !lvi_ev ##1 !wdt_ev && !lvi_ev |=> cause_q == 8'h00) // R3
        else $error("cause register not cleared by read");
    lv_regs_clear_a: assert property (clear_ev || wdt_ev |=> lowvolt_control_out == 8'h00 && lowvolt_level_out == 4'h0) // R4
        else $error("low-voltage registers not cleared");
    lv_regs_hold_a: assert property (lvi_ev && !clear_ev && !wdt_ev && !wr_lvctl && !wr_lvlvl
        |=> $stable(lowvolt_control_out) && $stable(lowvolt_level_out)) // R4
        else $error("low-voltage registers lost on low-voltage reset");
    unused_zero_a: assert property ((cause_q & 8'hee) == 8'h00) // R16
        else $error("unused cause bits set");
    below_detect_a: assert property (poc_low |=> internal_reset_out ##1 internal_reset_out) // R9
        else $error("reset not asserted below detect level");
    high_mode_a: assert property (mode_q && poc_latch_q |=> internal_reset_out) // R8
        else $error("released before release level");
    proc_len_a: assert property (state_q == rcpc_pkg::ST_PROC && state_d == rcpc_pkg::ST_RUN
        |-> st_cnt_q == 16'd189) // R10
        else $error("processing time wrong");
    stab_len_a: assert property (state_q == rcpc_pkg::ST_STAB && state_d == rcpc_pkg::ST_PROC
        |-> st_cnt_q == STAB_CYCLES - 16'h0001) // R10
        else $error("stabilization wait wrong");

    wdt_seen_c: cover property (wdt_ev ##1 cause_q[4]);
    lvi_seen_c: cover property (lvi_ev ##1 cause_q[0]);
    stab_run_c: cover property (state_q == rcpc_pkg::ST_STAB ##[1:1000] state_q == rcpc_pkg::ST_RUN);
    read_clr_c: cover property (rd_cause && cause_q != 8'h00);
endmodule

// ### hdl/rcpc_pkg.sv
// constants and types shared by the reset-cause and power-on-clear block
package rcpc_pkg;
    // register addresses
    localparam logic [15:0] CAUSE_ADDR = 16'hffac;
    localparam logic [15:0] LV_CTL_ADDR = 16'hffbe;
    localparam logic [15:0] LV_LVL_ADDR = 16'hffbf;
    // reset cause register fields
    localparam int WDT_FLAG_BIT = 4;
    localparam int LV_FLAG_BIT = 0;
    localparam logic [7:0] CAUSE_USED_MASK = 8'h11;
    localparam logic [7:0] CAUSE_RESET = 8'h00;
    // low-voltage control register fields
    localparam int LV_ON_BIT = 7;
    localparam int LV_SEL_BIT = 2;
    localparam int LV_MODE_BIT = 1;
    localparam int LV_DET_BIT = 0;
    localparam logic [7:0] LV_CTL_WMASK = 8'h86;
    localparam logic [7:0] LV_CTL_RESET = 8'h00;
    localparam logic [3:0] LV_LVL_RESET = 4'h0;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    // timing
    localparam int CLK_KHZ = 10_000;
    localparam int STAB_WAIT_US = 5390;
    localparam int PROC_MIN_US = 19;
    localparam int TMR_W = 16;
    // longest time: round down
    localparam int STAB_WAIT_CYC = (STAB_WAIT_US * CLK_KHZ) / 1000;
    // least time: round up
    localparam int PROC_CYC = (PROC_MIN_US * CLK_KHZ + 999) / 1000;
    // third edge: the second synchroniser stage holds the option only then
    localparam logic [1:0] STRAP_TAKE_CNT = 2'h3;
    // reset sequencer states
    typedef enum logic [1:0]
    {
        ST_HOLD = 2'b00,
        ST_STAB = 2'b01,
        ST_PROC = 2'b10,
        ST_RUN = 2'b11
    } rcpc_state_t;
endpackage

// ### hdl/rcpc_tmr_if.sv
// carrier between the sequencer and its wait timer
interface rcpc_tmr_if #(parameter int W = 16);
    logic start;
    logic [W-1:0] load;
    logic done;
    modport ctl (output start, output load, input done);
    modport tmr (input start, input load, output done);
endinterface

// ### hdl/rcpc_timer.sv
// down-counting wait timer, done high in the last cycle of the wait
module rcpc_timer #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // control
    rcpc_tmr_if.tmr tif
);
    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    logic [W-1:0] load_eff;

    // a zero load would never finish; one cycle is the floor
    assign load_eff = (tif.load == '0) ? W'(1) : tif.load;
    assign count_d = tif.start ? load_eff : ((count_q != '0) ? count_q - W'(1) : count_q);
    assign tif.done = (count_q == W'(1));

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            count_q <= '0;
        else
            count_q <= count_d;
    end
endmodule

// ### verif/rcpc_supply_model.sv
// supply comparators and reset pin driver facing the block
module rcpc_supply_model
(
    // supply zone: 0 below detect, 1 between levels, 2 above release
    input wire logic [1:0] zone_in,
    input wire logic pin_req_in,
    // to the block
    output logic ext_reset_pin_n_out,
    output logic below_detect_out,
    output logic above_release_out
);
    timeunit 1ns;
    timeprecision 1ns;
    assign ext_reset_pin_n_out = !pin_req_in && (zone_in != 2'h0);
    assign below_detect_out = (zone_in == 2'h0);
    assign above_release_out = (zone_in == 2'h2);
endmodule

// ### verif/rcpc_top_tb_top.sv
// self-checking bench for the reset cause and power-on-clear block
module rcpc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // short stabilization wait keeps the run brief
    localparam logic [15:0] STAB = 16'h0014;
    localparam int PROC = rcpc_pkg::PROC_CYC;
    logic clk_sys_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [1:0] zone = 2'h2;
    logic pin_req = 1'b0;
    logic lv_req = 1'b0;
    logic det = 1'b0;
    logic mode = 1'b0;
    logic wdt_req = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic below, above, pin_n, irst;
    logic [7:0] rdata, ctl;
    logic [3:0] lvl;
    logic [31:0] lfsr = 32'h36b7;
    int fail_count = 0;
    int compares = 0;
    int seq [15] = '{0, 1, 4, 1, 0, 4, 0, 2, 4, 1, 3, 4, 4, 0, 4};

    always #50 clk_sys_in = ~clk_sys_in;

    rcpc_supply_model model (.zone_in(zone), .pin_req_in(pin_req), .ext_reset_pin_n_out(pin_n),
        .below_detect_out(below), .above_release_out(above));
    rcpc_top #(.STAB_CYCLES(STAB)) uut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .ext_reset_pin_n_in(pin_n), .supply_below_detect_in(below), .supply_above_release_in(above),
        .lowvolt_reset_req_in(lv_req), .lowvolt_det_flag_in(det), .poweron_threshold_select_in(mode),
        .watchdog_reset_req_in(wdt_req), .addr_in(addr), .rd_in(rd), .wr_in(wr), .wdata_in(wdata),
        .rdata_out(rdata), .internal_reset_out(irst), .lowvolt_control_out(ctl), .lowvolt_level_out(lvl));

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] exp_ctl(input logic [7:0] w, input logic d);
        return (w & rcpc_pkg::LV_CTL_WMASK) | {7'h00, d};
    endfunction
    function automatic logic [7:0] exp_cause(input logic w, input logic l);
        return {3'h0, w, 3'h0, l};
    endfunction

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_span(input int got, input int lo, input int hi, input string what);
        compares++;
        if (got < lo || got > hi)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s took %0d cycles", $time, what, got);
        end
    endtask
    task automatic stop_test;
        $display("fail_count=%0d compares=%0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        @(posedge clk_sys_in);
        #1 d = rdata;
    endtask
    task automatic wait_release(output int n);
        n = 0;
        while (irst !== 1'b0 && n < 600)
        begin
            @(posedge clk_sys_in);
            #1 n++;
        end
    endtask

    initial
    begin
        #1_000_000;
        fail_count++;
        stop_test();
    end

    initial
    begin
        logic [7:0] d, w;
        logic ew, el;
        int n;
        ew = 1'b0;
        el = 1'b0;
        lfsr = next_rand(lfsr);
        // bit picked so the compare flag reads back as one
        det <= lfsr[1];
        repeat (4) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        wait_release(n);
        chk_span(n, PROC, PROC + 8, "low mode power-on");
        reg_rd(rcpc_pkg::CAUSE_ADDR, d);
        chk_byte(d, rcpc_pkg::CAUSE_RESET, "cause after power-on");
        reg_wr(rcpc_pkg::CAUSE_ADDR, 8'hff);
        reg_rd(rcpc_pkg::CAUSE_ADDR, d);
        chk_byte(d, 8'h00, "cause after write");
        // port set-up writes land outside the block
        reg_wr(16'hffad, 8'h01);
        reg_rd(16'hffad, d);
        chk_byte(d, rcpc_pkg::UNMAPPED_DATA, "unmapped read");
        // 0 watchdog, 1 low-voltage, 2 pin, 3 power-on, 4 read cause
        foreach (seq[i])
        begin
            if (seq[i] == 4)
            begin
                reg_rd(rcpc_pkg::CAUSE_ADDR, d);
                chk_byte(d, exp_cause(ew, el), "cause read");
                ew = 1'b0;
                el = 1'b0;
            end
            else
            begin
                lfsr = next_rand(lfsr);
                w = lfsr[7:0];
                reg_wr(rcpc_pkg::LV_CTL_ADDR, w);
                reg_wr(rcpc_pkg::LV_LVL_ADDR, {4'h0, lfsr[11:8]});
                @(posedge clk_sys_in);
                #1 chk_byte(ctl, w & rcpc_pkg::LV_CTL_WMASK, "ctl write");
                reg_rd(rcpc_pkg::LV_CTL_ADDR, d);
                chk_byte(d, exp_ctl(w, det), "ctl readback");
                @(posedge clk_sys_in);
                case (seq[i])
                    0: wdt_req <= 1'b1;
                    1: lv_req <= 1'b1;
                    2: pin_req <= 1'b1;
                    default: zone <= 2'h0;
                endcase
                ew = (seq[i] == 0) | (ew & (seq[i] == 1));
                el = (seq[i] == 1) | (el & (seq[i] == 0));
                repeat (4) @(posedge clk_sys_in);
                #1 chk_byte({7'h00, irst}, 8'h01, "reset asserted");
                chk_byte(ctl, seq[i] == 1 ? (w & rcpc_pkg::LV_CTL_WMASK) : 8'h00, "ctl after reset");
                chk_byte({4'h0, lvl}, seq[i] == 1 ? {4'h0, lfsr[11:8]} : 8'h00, "lvl after reset");
                @(posedge clk_sys_in);
                wdt_req <= 1'b0;
                lv_req <= 1'b0;
                pin_req <= 1'b0;
                zone <= (zone == 2'h0) ? 2'h1 : zone;
                wait_release(n);
                chk_span(n, PROC, PROC + 8, "release time");
            end
        end
        // high mode: power-on, then a brownout
        @(posedge clk_sys_in);
        nrst_in <= 1'b0;
        mode <= 1'b1;
        zone <= 2'h1;
        repeat (4) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        for (int j = 0; j < 2; j++)
        begin
            if (j == 1)
            begin
                @(posedge clk_sys_in);
                zone <= 2'h0;
                repeat (4) @(posedge clk_sys_in);
                zone <= 2'h1;
            end
            repeat (300) @(posedge clk_sys_in);
            #1 chk_byte({7'h00, irst}, 8'h01, "held between levels");
            @(posedge clk_sys_in);
            zone <= 2'h2;
            wait_release(n);
            chk_span(n, int'(STAB) + PROC, int'(STAB) + PROC + 8, "high mode release");
        end
        repeat (8) @(posedge clk_sys_in);
        reg_rd(rcpc_pkg::CAUSE_ADDR, d);
        chk_byte(d, 8'h00, "cause after brownout");
        stop_test();
    end
endmodule
